/* src/pmbc_pkg.sv */
// package: register map, fields, modes and timing of the power mode and boost controller
package pmbc_pkg;
  // ==========================================
  // register offsets (byte addresses)
  localparam logic [11:0] PMBC_OFF_MODE_CTRL = 12'h000;
  localparam logic [11:0] PMBC_OFF_ACT_TMPL = 12'h004;
  localparam logic [11:0] PMBC_OFF_ALT_TMPL = 12'h008;
  localparam logic [11:0] PMBC_OFF_WAKE_EN = 12'h00C;
  localparam logic [11:0] PMBC_OFF_TW_PERIOD = 12'h010;
  localparam logic [11:0] PMBC_OFF_BOOST_CTRL = 12'h014;
  localparam logic [11:0] PMBC_OFF_STATUS = 12'h018;
  localparam logic [11:0] PMBC_OFF_WAKE_SRC = 12'h01C;
  // ==========================================
  // widths and field positions
  localparam int PMBC_NRES = 16;
  localparam int PMBC_NWAKE = 7;
  localparam int PMBC_CPU_BIT = 0;
  localparam int PMBC_FLASH_BIT = 1;
  localparam logic [2:0] PMBC_REQ_NONE = 3'h0;
  localparam logic [2:0] PMBC_REQ_ALT = 3'h1;
  localparam logic [2:0] PMBC_REQ_SLEEP = 3'h2;
  localparam logic [2:0] PMBC_REQ_HIB = 3'h3;
  localparam logic [2:0] PMBC_REQ_CPU_OFF = 3'h4;
  // wake source bits: 0 periph irq, 1 supervisor, 2 timewheel, 3 io irq, 4 ext reset, 5 watchdog, 6 precise lv reset
  localparam int PMBC_WK_TW = 2;
  localparam int PMBC_WK_IO = 3;
  localparam logic [PMBC_NRES-1:0] PMBC_ACT_TMPL_RST = 16'hFFFF;
  localparam logic [PMBC_NRES-1:0] PMBC_ALT_TMPL_RST = 16'hFFFC;
  localparam logic [PMBC_NWAKE-1:0] PMBC_WAKE_EN_RST = 7'h7F;
  localparam logic [5:0] PMBC_BOOST_SEL_MAX = 6'h20;  // 1.8 V + 32 x 100 mV = 5.0 V
  localparam logic [5:0] PMBC_BOOST_SEL_RST = 6'h0F;  // 3.3 V
  localparam logic [31:0] PMBC_TW_PERIOD_RST = 32'h0000_FFFF;
  // ==========================================
  // timing
  localparam int PMBC_CLK_MHZ = 100;
  localparam int PMBC_SLEEP_RESUME_NS = 15000;
  localparam int PMBC_HIB_RESUME_NS = 99000;  // kept below 100 us
  localparam int PMBC_SLEEP_CYC = (PMBC_SLEEP_RESUME_NS * PMBC_CLK_MHZ + 999) / 1000;
  localparam int PMBC_HIB_CYC = (PMBC_HIB_RESUME_NS * PMBC_CLK_MHZ) / 1000;
  localparam int PMBC_BOOST_KHZ = 400;
  localparam int PMBC_BOOST_DIV = (PMBC_CLK_MHZ * 1000) / (2 * PMBC_BOOST_KHZ);
  // ==========================================
  // global modes, gray coded along sleep-resume-active
  typedef enum logic [2:0] {
    PMBC_ACTIVE = 3'b000,
    PMBC_ALT = 3'b001,
    PMBC_SLEEP = 3'b011,
    PMBC_SLEEP_RES = 3'b010,
    PMBC_HIB = 3'b110,
    PMBC_HIB_RES = 3'b111
  } pmbc_mode_e;
endpackage

/* src/pmbc_tick_if.sv */
// interface: timewheel configuration and tick between the controller and its timer
`timescale 1ns/1ps
interface pmbc_tick_if;
  logic [31:0] period;
  logic run;
  logic tick;
  modport ctrl (output period, output run, input tick);
  modport timer (input period, input run, output tick);
endinterface

/* src/pmbc_timewheel.sv */
// central timewheel: periodic tick counter
`timescale 1ns/1ps
module pmbc_timewheel
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // link to controller
  pmbc_tick_if.timer tk
);
  import pmbc_pkg::*;
  typedef struct packed
  {
    logic [31:0] cnt;
    logic tick;
  } pmbc_tw_s;
  pmbc_tw_s st_q, st_d;
  // count down, pulse tick at zero
  always_comb
  begin
    st_d = st_q;
    st_d.tick = 1'b0;
    if (!tk.run)
      st_d.cnt = tk.period;
    else if (st_q.cnt == 32'h0000_0000)
    begin
      st_d.cnt = tk.period;
      st_d.tick = 1'b1;
    end
    else
      st_d.cnt = st_q.cnt - 32'h0000_0001;
  end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      st_q <= '0;
    else
      st_q <= st_d;
  end
  assign tk.tick = st_q.tick;
endmodule

/* src/pmbc_boost_osc.sv */
// boost switching clock: 400 kHz from the fast clock
`timescale 1ns/1ps
module pmbc_boost_osc
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // control
  input wire logic run,
  // switching clock out
  output logic sw_clk
);
  import pmbc_pkg::*;
  typedef struct packed
  {
    logic [7:0] cnt;
    logic clk;
  } pmbc_osc_s;
  pmbc_osc_s st_q, st_d;
  // half period divider; stops low in standby
  always_comb
  begin
    st_d = st_q;
    if (!run)
    begin
      st_d.cnt = '0;
      st_d.clk = 1'b0;
    end
    else if (st_q.cnt == 8'(PMBC_BOOST_DIV - 1))
    begin
      st_d.cnt = '0;
      st_d.clk = ~st_q.clk;
    end
    else
      st_d.cnt = st_q.cnt + 8'h01;
  end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      st_q <= '0;
    else
      st_q <= st_d;
  end
  assign sw_clk = st_q.clk;
endmodule

/* src/pmbc_top.sv */
// power mode and boost controller: global modes, templates, wakeup and boost coupling
// Notes on behaviour
// - active mode: template bits gate resource clocks
// - cpu may stop itself; wakeup restarts
// - wakeup in active or alt forces active mode; any wakeup turns cpu on
// - reset leaves controller in active mode
// - alternate active uses reduced alternate template
// - sleep resume waits 15 us before active
// - hibernate holds config, outputs, pin irq
// - hibernate exits on io irq, under 100 us
// - wake on irqs, timewheel, resets
// - timewheel gives periodic wakeup ticks
// - boost switches 400 kHz when active, stops low in standby
// - boost level 1.8 to 5.0 V, 100 mV
`timescale 1ns/1ps
module pmbc_top
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // wakeup sources
  input wire logic [pmbc_pkg::PMBC_NWAKE-1:0] wake_in,
  // resource control
  output logic [pmbc_pkg::PMBC_NRES-1:0] res_clk_en,
  output logic cpu_en,
  output logic hold_io,
  output logic [2:0] mode_out,
  // boost regulator
  output logic boost_active,
  output logic [5:0] boost_sel,
  output logic boost_sw_clk,
  output logic fast_osc_sel
);
  import pmbc_pkg::*;
  // ==========================================
  // state
  typedef struct packed
  {
    pmbc_mode_e mode;
    logic [PMBC_NRES-1:0] act_tmpl;
    logic [PMBC_NRES-1:0] alt_tmpl;
    logic [PMBC_NWAKE-1:0] wake_en;
    logic [PMBC_NWAKE-1:0] wake_src;
    logic [31:0] tw_period;
    logic tw_run;
    logic [5:0] boost_sel;
    logic boost_sleep_stby;
    logic boost_hib_act;
    logic fast_osc;
    logic cpu_off;
    logic [16:0] wait_cnt;
    logic [16:0] res_cyc;
    logic [PMBC_NRES-1:0] clk_en;
    logic [31:0] rdata;
  } pmbc_top_s;
  pmbc_top_s st_q, st_d;
  pmbc_tick_if tk ();
  logic wr, rd, hit;
  logic [PMBC_NWAKE-1:0] wake_ev;
  logic any_wake;
  logic running;
  // decode of mapped offsets
  function automatic logic pmbc_mapped(input logic [11:0] a);
    return (a <= PMBC_OFF_WAKE_SRC) && (a[1:0] == 2'b00);
  endfunction
  // ==========================================
  // bus strobes: always ready in access phase
  assign wr = psel && penable && pwrite;
  assign rd = psel && !penable && !pwrite;
  assign hit = pmbc_mapped(paddr);
  assign pready = 1'b1;
  assign pslverr = psel && penable && !hit;
  // ==========================================
  // wake event qualification, timewheel folded in
  always_comb
  begin
    wake_ev = wake_in;
    wake_ev[PMBC_WK_TW] = wake_in[PMBC_WK_TW] | tk.tick;
    wake_ev = wake_ev & st_q.wake_en;
  end
  assign any_wake = |wake_ev;
  assign running = (st_q.mode == PMBC_ACTIVE) || (st_q.mode == PMBC_ALT);
  // ==========================================
  // next state
  always_comb
  begin
    st_d = st_q;
    // sticky wake record, new event beats clear
    if (wr && paddr == PMBC_OFF_WAKE_SRC)
      st_d.wake_src = st_q.wake_src & ~pwdata[PMBC_NWAKE-1:0];
    st_d.wake_src = st_d.wake_src | wake_ev;
    // register writes; accepted in every mode, hibernate included
    if (wr && hit)
    begin
      case (paddr)
        PMBC_OFF_ACT_TMPL: st_d.act_tmpl = pwdata[PMBC_NRES-1:0];
        PMBC_OFF_ALT_TMPL: st_d.alt_tmpl = pwdata[PMBC_NRES-1:0];
        PMBC_OFF_WAKE_EN: st_d.wake_en = pwdata[PMBC_NWAKE-1:0];
        PMBC_OFF_TW_PERIOD:
        begin
          st_d.tw_period = pwdata;
        end
        PMBC_OFF_BOOST_CTRL:
        begin
          // clamp level code to 5.0 V
          st_d.boost_sel = (pwdata[5:0] > PMBC_BOOST_SEL_MAX) ? PMBC_BOOST_SEL_MAX : pwdata[5:0];
          st_d.boost_sleep_stby = pwdata[8];
          st_d.boost_hib_act = pwdata[9];
          st_d.fast_osc = pwdata[10];
          st_d.tw_run = pwdata[11];
        end
        default: st_d.tw_run = st_d.tw_run;
      endcase
    end
    // mode machine
    case (st_q.mode)
      PMBC_ACTIVE:
      begin
        if (wr && paddr == PMBC_OFF_MODE_CTRL && !any_wake)
        begin
          // low power entry only from active
          case (pwdata[2:0])
            PMBC_REQ_ALT: st_d.mode = PMBC_ALT;
            PMBC_REQ_SLEEP: st_d.mode = PMBC_SLEEP;
            PMBC_REQ_HIB: st_d.mode = PMBC_HIB;
            PMBC_REQ_CPU_OFF: st_d.cpu_off = 1'b1;
            default: st_d.mode = PMBC_ACTIVE;
          endcase
        end
      end
      PMBC_ALT:
      begin
        if (any_wake || (wr && paddr == PMBC_OFF_MODE_CTRL && pwdata[2:0] == PMBC_REQ_NONE))
          st_d.mode = PMBC_ACTIVE;
      end
      PMBC_SLEEP:
      begin
        if (any_wake)
        begin
          st_d.mode = PMBC_SLEEP_RES;
          st_d.wait_cnt = 17'(PMBC_SLEEP_CYC - 1);
        end
      end
      PMBC_HIB:
      begin
        // only the io interrupt ends hibernate
        if (wake_ev[PMBC_WK_IO])
        begin
          st_d.mode = PMBC_HIB_RES;
          st_d.wait_cnt = 17'(PMBC_HIB_CYC - 1);
        end
      end
      PMBC_SLEEP_RES, PMBC_HIB_RES:
      begin
        if (st_q.wait_cnt == 17'h0_0000)
          st_d.mode = PMBC_ACTIVE;
        else
          st_d.wait_cnt = st_q.wait_cnt - 17'h0_0001;
      end
      default: st_d.mode = PMBC_ACTIVE;
    endcase
    // wakeup in a running mode returns to active, cpu on
    if (any_wake && running)
      st_d.mode = PMBC_ACTIVE;
    if (any_wake)
      st_d.cpu_off = 1'b0;
    // free count of resume cycles, kept apart from wait_cnt so the check is independent
    if ((st_q.mode == PMBC_SLEEP_RES) || (st_q.mode == PMBC_HIB_RES))
      st_d.res_cyc = st_q.res_cyc + 17'h0_0001;
    else
      st_d.res_cyc = 17'h0_0000;
    // clock gates follow the template of the mode
    case (st_d.mode)
      PMBC_ACTIVE: st_d.clk_en = st_d.act_tmpl;
      PMBC_ALT: st_d.clk_en = st_d.alt_tmpl;
      default: st_d.clk_en = '0;
    endcase
    if (st_d.cpu_off)
      st_d.clk_en[PMBC_CPU_BIT] = 1'b0;
    // read data registered in setup phase
    st_d.rdata = '0;
    if (rd)
    begin
      case (paddr)
        PMBC_OFF_MODE_CTRL: st_d.rdata = {29'h0, st_q.mode};
        PMBC_OFF_ACT_TMPL: st_d.rdata = {16'h0000, st_q.act_tmpl};
        PMBC_OFF_ALT_TMPL: st_d.rdata = {16'h0000, st_q.alt_tmpl};
        PMBC_OFF_WAKE_EN: st_d.rdata = {25'h0, st_q.wake_en};
        PMBC_OFF_TW_PERIOD: st_d.rdata = st_q.tw_period;
        PMBC_OFF_BOOST_CTRL:
          st_d.rdata = {20'h0, st_q.tw_run, st_q.fast_osc, st_q.boost_hib_act, st_q.boost_sleep_stby,
            2'b00, st_q.boost_sel};
        PMBC_OFF_STATUS: st_d.rdata = {16'h0000, st_q.clk_en};
        PMBC_OFF_WAKE_SRC: st_d.rdata = {25'h0, st_q.wake_src};
        default: st_d.rdata = '0;
      endcase
    end
  end
  // ==========================================
  // registers; reset puts the chip in active
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_q <= '0;
      st_q.mode <= PMBC_ACTIVE;
      st_q.act_tmpl <= PMBC_ACT_TMPL_RST;
      st_q.alt_tmpl <= PMBC_ALT_TMPL_RST;
      st_q.wake_en <= PMBC_WAKE_EN_RST;
      st_q.tw_period <= PMBC_TW_PERIOD_RST;
      st_q.boost_sel <= PMBC_BOOST_SEL_RST;
      st_q.clk_en <= PMBC_ACT_TMPL_RST;
    end
    else
      st_q <= st_d;
  end
  // ==========================================
  // timewheel and boost oscillator
  assign tk.period = st_q.tw_period;
  assign tk.run = st_q.tw_run;
  pmbc_timewheel u_tw
  (
    .pclk(pclk),
    .presetn(presetn),
    .tk(tk)
  );
  // boost active when running, or by choice in sleep/hibernate
  assign boost_active = running || (st_q.mode == PMBC_SLEEP_RES) || (st_q.mode == PMBC_HIB_RES) ||
    (st_q.mode == PMBC_SLEEP && !st_q.boost_sleep_stby) || (st_q.mode == PMBC_HIB && st_q.boost_hib_act);
  pmbc_boost_osc u_osc
  (
    .pclk(pclk),
    .presetn(presetn),
    .run(boost_active),
    .sw_clk(boost_sw_clk)
  );
  // ==========================================
  // outputs
  assign prdata = st_q.rdata;
  assign res_clk_en = st_q.clk_en;
  assign cpu_en = st_q.clk_en[PMBC_CPU_BIT];
  // hold pins and state in hibernate
  assign hold_io = (st_q.mode == PMBC_HIB);
  assign mode_out = st_q.mode;
  assign boost_sel = st_q.boost_sel;
  // slow startup clock unless chosen fast
  assign fast_osc_sel = st_q.fast_osc;
  // ==========================================
  // assertions
  property p_tmpl_gate;
    @(posedge pclk) disable iff (!presetn)
    (st_q.mode == PMBC_ACTIVE && !st_q.cpu_off) |-> res_clk_en == st_q.act_tmpl;
  endproperty
  a_tmpl_gate: assert property (p_tmpl_gate) else $error("active clocks differ from template");
  property p_live_edit;
    @(posedge pclk) disable iff (!presetn)
    (wr && paddr == PMBC_OFF_ACT_TMPL && st_q.mode == PMBC_ACTIVE && !any_wake && !st_q.cpu_off)
      |=> st_q.act_tmpl == $past(pwdata[PMBC_NRES-1:0]);
  endproperty
  a_live_edit: assert property (p_live_edit) else $error("template write lost");
  property p_cpu_back;
    @(posedge pclk) disable iff (!presetn)
    (st_q.cpu_off && any_wake && running) |=> cpu_en == st_q.act_tmpl[PMBC_CPU_BIT];
  endproperty
  a_cpu_back: assert property (p_cpu_back) else $error("cpu not restored on wake");
  property p_wake_active;
    @(posedge pclk) disable iff (!presetn)
    (any_wake && running) |=> st_q.mode == PMBC_ACTIVE;
  endproperty
  a_wake_active: assert property (p_wake_active) else $error("wake did not return to active");
  property p_alt_tmpl;
    @(posedge pclk) disable iff (!presetn)
    (st_q.mode == PMBC_ALT && !st_q.cpu_off) |-> res_clk_en == st_q.alt_tmpl;
  endproperty
  a_alt_tmpl: assert property (p_alt_tmpl) else $error("alternate clocks differ from template");
  property p_sleep_res;
    @(posedge pclk) disable iff (!presetn)
    (st_q.mode == PMBC_SLEEP_RES && st_d.mode == PMBC_ACTIVE) |-> st_q.res_cyc == 17'(PMBC_SLEEP_CYC - 1);
  endproperty
  a_sleep_res: assert property (p_sleep_res) else $error("sleep resume too short");
  property p_hib_hold;
    @(posedge pclk) disable iff (!presetn)
    (st_q.mode == PMBC_HIB) |-> hold_io && res_clk_en == '0;
  endproperty
  a_hib_hold: assert property (p_hib_hold) else $error("hibernate not holding");
  property p_hib_exit;
    @(posedge pclk) disable iff (!presetn)
    (st_q.mode == PMBC_HIB && !wake_ev[PMBC_WK_IO]) |=> st_q.mode == PMBC_HIB;
  endproperty
  a_hib_exit: assert property (p_hib_exit) else $error("hibernate left without io wake");
  property p_boost_run;
    @(posedge pclk) disable iff (!presetn)
    running |-> boost_active;
  endproperty
  a_boost_run: assert property (p_boost_run) else $error("boost idle while running");
  property p_boost_lvl;
    @(posedge pclk) disable iff (!presetn)
    boost_sel <= PMBC_BOOST_SEL_MAX;
  endproperty
  a_boost_lvl: assert property (p_boost_lvl) else $error("boost level out of range");
  property p_entry;
    @(posedge pclk) disable iff (!presetn)
    ($changed(st_q.mode) && (st_q.mode == PMBC_SLEEP || st_q.mode == PMBC_HIB)) |-> $past(st_q.mode) == PMBC_ACTIVE;
  endproperty
  a_entry: assert property (p_entry) else $error("low power entered from wrong mode");
  c_sleep: cover property (@(posedge pclk) disable iff (!presetn) st_q.mode == PMBC_SLEEP_RES ##1 st_q.mode == PMBC_ACTIVE);
  c_hib: cover property (@(posedge pclk) disable iff (!presetn) st_q.mode == PMBC_HIB_RES ##1 st_q.mode == PMBC_ACTIVE);
  c_alt: cover property (@(posedge pclk) disable iff (!presetn) st_q.mode == PMBC_ALT ##1 st_q.mode == PMBC_ACTIVE);
  c_tick: cover property (@(posedge pclk) disable iff (!presetn) tk.tick && st_q.mode == PMBC_SLEEP);
endmodule

/* verif/pmbc_top_tb.sv */
// testbench: apb driven checks of modes, templates, wakeup and boost coupling
`timescale 1ns/1ps
module pmbc_top_tb;
  import pmbc_pkg::*;
  // ==========================================
  // signals
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [PMBC_NWAKE-1:0] wake_in = '0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [PMBC_NRES-1:0] res_clk_en;
  logic cpu_en;
  logic hold_io;
  logic [2:0] mode_out;
  logic boost_active;
  logic [5:0] boost_sel;
  logic boost_sw_clk;
  logic fast_osc_sel;
  int num_errors = 0;
  int tests_run = 0;
  int n;
  logic [31:0] r;
  logic e;
  // 100 mhz clock
  always #5 pclk = ~pclk;
  pmbc_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .wake_in(wake_in), .res_clk_en(res_clk_en), .cpu_en(cpu_en), .hold_io(hold_io),
    .mode_out(mode_out), .boost_active(boost_active), .boost_sel(boost_sel),
    .boost_sw_clk(boost_sw_clk), .fast_osc_sel(fast_osc_sel));
  // ==========================================
  // helpers
  task results;
    $display("checks %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    tests_run++;
    if (got !== exp)
    begin
      num_errors++;
      $display("BAD %0t %s", $time, msg);
    end
  endtask
  // one apb transfer; request held until pready is seen high
  task xfer(input logic [11:0] a, input logic w, input logic [31:0] wd, output logic [31:0] rd, output logic er);
    int k;
    begin
      k = 0;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1)
      begin
        k++;
        if (k > 50)
        begin
          chk(0, 1, "no pready");
          results;
        end
        @(posedge pclk);
      end
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d);
    xfer(a, 1'b1, d, r, e);
  endtask
  task rdc(input logic [11:0] a, input logic [31:0] x, input string msg);
    xfer(a, 1'b0, 32'h0000_0000, r, e);
    chk(r, x, msg);
  endtask
  task cyc(input int k);
    repeat (k) @(posedge pclk);
  endtask
  // bounded wait for a mode code, cycles counted in n
  task wmode(input logic [2:0] m, input int lim);
    n = 0;
    while (mode_out !== m)
    begin
      @(posedge pclk);
      n++;
      if (n > lim)
      begin
        chk(0, 1, "mode wait");
        results;
      end
    end
  endtask
  // bounded wait for a level on the boost switching clock
  task wsw(input logic v);
    n = 0;
    while (boost_sw_clk !== v)
    begin
      @(posedge pclk);
      n++;
      if (n > 400)
      begin
        chk(0, 1, "sw clk wait");
        results;
      end
    end
  endtask
  // one-cycle wake pulse, never two assignments in one step
  task pulse(input logic [PMBC_NWAKE-1:0] m);
    @(posedge pclk);
    wake_in <= m;
    @(posedge pclk);
    wake_in <= '0;
  endtask
  // ==========================================
  // main sequence
  initial
  begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    cyc(2);
    chk(32'(mode_out), 32'h0000_0000, "reset mode");
    chk(32'(res_clk_en), 32'h0000_FFFF, "reset enables");
    chk(32'({cpu_en, boost_active, hold_io, fast_osc_sel}), 32'h0000_000C, "reset flags");
    chk(32'(boost_sel), 32'h0000_000F, "reset level");
    rdc(PMBC_OFF_MODE_CTRL, 32'h0000_0000, "mode reg");
    rdc(PMBC_OFF_ACT_TMPL, 32'h0000_FFFF, "act tmpl");
    rdc(PMBC_OFF_ALT_TMPL, 32'h0000_FFFC, "alt tmpl");
    rdc(PMBC_OFF_WAKE_EN, 32'h0000_007F, "wake en");
    rdc(PMBC_OFF_TW_PERIOD, 32'h0000_FFFF, "tw period");
    $display("test reset done");
    // live template edit without a mode change
    wr(PMBC_OFF_ACT_TMPL, 32'h0000_00A5);
    cyc(3);
    chk(32'(res_clk_en), 32'h0000_00A5, "live tmpl");
    rdc(PMBC_OFF_STATUS, 32'h0000_00A5, "status");
    wr(PMBC_OFF_ACT_TMPL, 32'h0000_FFFF);
    $display("test template done");
    // alternate active, then a refused sleep request from alt
    wr(PMBC_OFF_MODE_CTRL, 32'h0000_0001);
    wmode(3'b001, 20);
    cyc(2);
    chk(32'(res_clk_en), 32'h0000_FFFC, "alt enables");
    chk(32'(boost_active), 32'h0000_0001, "boost in alt");
    wr(PMBC_OFF_MODE_CTRL, 32'h0000_0002);
    cyc(3);
    chk(32'(mode_out), 32'h0000_0001, "sleep from alt");
    wr(PMBC_OFF_MODE_CTRL, 32'h0000_0000);
    wmode(3'b000, 20);
    $display("test alt done");
    // cpu stops itself; each wake source restarts it
    for (int i = 0; i < PMBC_NWAKE; i++)
    begin
      wr(PMBC_OFF_MODE_CTRL, 32'h0000_0004);
      cyc(3);
      chk(32'(cpu_en), 32'h0000_0000, "cpu off");
      pulse(PMBC_NWAKE'(1 << i));
      cyc(3);
      chk(32'({cpu_en, mode_out}), 32'h0000_0008, "wake cpu on");
    end
    rdc(PMBC_OFF_WAKE_SRC, 32'h0000_007F, "wake sticky");
    wr(PMBC_OFF_WAKE_SRC, 32'h0000_007F);
    rdc(PMBC_OFF_WAKE_SRC, 32'h0000_0000, "wake clear");
    // a masked source must not wake
    wr(PMBC_OFF_WAKE_EN, 32'h0000_007E);
    wr(PMBC_OFF_MODE_CTRL, 32'h0000_0004);
    pulse(7'h01);
    cyc(3);
    chk(32'(cpu_en), 32'h0000_0000, "masked wake");
    pulse(7'h02);
    cyc(3);
    chk(32'(cpu_en), 32'h0000_0001, "enabled wake");
    wr(PMBC_OFF_WAKE_EN, 32'h0000_007F);
    $display("test wakeup done");
    // sleep and its 15 us resume at 100 mhz
    wr(PMBC_OFF_MODE_CTRL, 32'h0000_0002);
    wmode(3'b011, 20);
    cyc(2);
    chk(32'({boost_active, res_clk_en}), 32'h0001_0000, "sleep state");
    pulse(7'h01);
    wmode(3'b010, 20);
    wmode(3'b000, 2000);
    chk(32'(n >= 1498 && n <= 1502), 32'h0000_0001, "sleep resume time");
    $display("test sleep done");
    // hibernate keeps state, wakes only on io, under 10000 cycles
    wr(PMBC_OFF_ACT_TMPL, 32'h0000_1235);
    wr(PMBC_OFF_MODE_CTRL, 32'h0000_0003);
    wmode(3'b110, 20);
    cyc(2);
    chk(32'({hold_io, boost_active, res_clk_en}), 32'h0002_0000, "hib state");
    pulse(7'h01);
    cyc(10);
    chk(32'(mode_out), 32'h0000_0006, "non io wake in hib");
    pulse(7'h08);
    wmode(3'b111, 20);
    wmode(3'b000, 10500);
    chk(32'(n < 10000), 32'h0000_0001, "hib resume time");
    cyc(3);
    chk(32'({hold_io, res_clk_en}), 32'h0000_1235, "hib retained");
    rdc(PMBC_OFF_ACT_TMPL, 32'h0000_1235, "hib tmpl");
    wr(PMBC_OFF_ACT_TMPL, 32'h0000_FFFF);
    $display("test hibernate done");
    // level clamp, startup clock and 400 khz switching
    wr(PMBC_OFF_BOOST_CTRL, 32'h0000_003F);
    cyc(3);
    chk(32'(boost_sel), 32'h0000_0020, "level clamp");
    wr(PMBC_OFF_BOOST_CTRL, 32'h0000_0413);
    cyc(3);
    chk(32'({fast_osc_sel, boost_sel}), 32'h0000_0053, "level and clock");
    wsw(1'b0);
    wsw(1'b1);
    wsw(1'b0);
    chk(32'(n), 32'h0000_007D, "half period");
    $display("test boost done");
    // timewheel tick wakes sleep; boost standby meanwhile
    wr(PMBC_OFF_TW_PERIOD, 32'h0000_00C8);
    wr(PMBC_OFF_BOOST_CTRL, 32'h0000_090F);
    wr(PMBC_OFF_MODE_CTRL, 32'h0000_0002);
    wmode(3'b011, 20);
    cyc(2);
    chk(32'(boost_active), 32'h0000_0000, "standby in sleep");
    wmode(3'b010, 1000);
    wmode(3'b000, 2000);
    wr(PMBC_OFF_BOOST_CTRL, 32'h0000_000F);
    cyc(2);
    chk(32'(boost_active), 32'h0000_0001, "boost active again");
    $display("test timewheel done");
    // unmapped and misaligned places are refused
    xfer(12'h020, 1'b0, 32'h0000_0000, r, e);
    chk(32'({e, r[30:0]}), 32'h8000_0000, "unmapped read");
    xfer(12'h005, 1'b1, 32'h0000_0001, r, e);
    chk(32'(e), 32'h0000_0001, "misaligned write");
    $display("test refuse done");
    results;
  end
endmodule
